// file: pkg/scp_pkg.sv
// Constants and types for the serial configuration port and power control
package scp_pkg;
    // Register offsets (13-bit register address space)
    localparam logic [12:0] ADDR_CFG = 13'h000;
    localparam logic [12:0] ADDR_PLL = 13'h010;
    localparam logic [12:0] ADDR_DIST = 13'h230;
    localparam logic [12:0] ADDR_UPD = 13'h232;
    localparam logic [12:0] ADDR_LAST = 13'h232;
    localparam logic [12:0] ADDR_STEP = 13'h001;
    // Port configuration fields; soft reset and long instruction are mirrored pairs, SDO and LSB-first single bits
    localparam int CFG_SDO_BIT = 7;
    localparam int CFG_LSB_BIT = 6;
    localparam int CFG_SRST_BIT = 5;
    localparam int CFG_SRST_MIR = 2;
    localparam logic [7:0] CFG_LONG_MASK = 8'h18;
    localparam logic [7:0] CFG_SRST_MASK = 8'h24;
    localparam logic [7:0] CFG_RESET = 8'h18;
    // Other reset values
    localparam logic [7:0] PLL_RESET = 8'h00;
    localparam logic [7:0] DIST_RESET = 8'h00;
    // Field positions
    localparam int DIST_PD_BIT = 1;
    localparam int SOFT_SYNC_BIT = 0;
    localparam int UPD_BIT = 0;
    // PLL operating mode codes
    localparam logic [1:0] PLL_NORMAL = 2'h0;
    localparam logic [1:0] PLL_ASYNC_PD = 2'h1;
    localparam logic [1:0] PLL_SYNC_PD = 2'h3;
    // LVPECL power-down mode codes
    localparam logic [1:0] PECL_NORMAL = 2'h0;
    localparam logic [1:0] PECL_SAFE = 2'h2;
    localparam logic [1:0] PECL_TOTAL = 2'h3;
    // Transfer length code for streaming
    localparam logic [1:0] LEN_STREAM = 2'h3;
    localparam logic [3:0] INSTR_LAST = 4'hF;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    // Pin synchronizer reset: chip select and sleep pin idle high
    localparam logic [4:0] SYNC_RESET = 5'h0A;
    // Output alignment hold after any reset
    localparam int ALIGN_NS = 100;
    localparam int CLK_MHZ = 40;
    localparam int ALIGN_CYC = (ALIGN_NS * CLK_MHZ + 999) / 1000;
    // Serial port sequencer states
    typedef enum logic [1:0] {
        ST_INSTR = 2'b00,
        ST_DATA = 2'b01,
        ST_DONE = 2'b10
    } scp_state_type;
endpackage

// file: verilog/scp_port_ctrl.sv
// Serial configuration port, write buffer FIFO and reset/power-down control
`timescale 1ns/1ps

module scp_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int IW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [IW-1:0] wp, rp, next_wp, next_rp;
    logic [IW:0] cnt, next_cnt;
    logic push, pop;

    // Pointers wrap by width, so only powers of two work
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("FIFO depth must be a power of two");
    end

    assign in_ready = (cnt != (IW+1)'(DEPTH));
    assign out_valid = (cnt != '0);
    assign out_data = mem[rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Next pointer and fill level
    always_comb begin
        next_wp = push ? wp + IW'(1) : wp;
        next_rp = pop ? rp + IW'(1) : rp;
        next_cnt = cnt + (IW+1)'(push) - (IW+1)'(pop);
        if (!rst_n) begin
            next_wp = '0;
            next_rp = '0;
            next_cnt = '0;
        end
    end

    always_ff @(posedge clk) begin
        wp <= next_wp;
        rp <= next_rp;
        cnt <= next_cnt;
        if (push) begin
            mem[wp] <= in_data;
        end
    end
endmodule

module scp_port_ctrl
    import scp_pkg::*;
#(
    parameter int PECL_OUTS = 6,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hard_reset_n,
    input wire logic sleep_pin_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    output logic separate_readback_pin,
    output logic separate_readback_oe,
    input wire logic cp_event,
    input wire logic [2*PECL_OUTS-1:0] lvpecl_pd_code,
    output logic pll_off,
    output logic vco_off,
    output logic clk_buf_off,
    output logic dividers_off,
    output logic lvds_cmos_off,
    output logic dist_bias_off,
    output logic [2*PECL_OUTS-1:0] lvpecl_state,
    output logic align_hold,
    output logic write_buf_ready
);
    if (PECL_OUTS < 1) begin : g_bad_outs
        $error("At least one LVPECL output is needed");
    end

    logic [4:0] sync_a, sync_b;
    logic sclk_d, cs_d, cp_d;
    logic sclk_s, cs_s, din_s, sleep_s, cp_s;
    logic rise, fall, cs_rise, cp_rise;

    // Pins pass two flops; stage a feeds stage b only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_a <= SYNC_RESET;
            sync_b <= SYNC_RESET;
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
            cp_d <= 1'b0;
        end else begin
            sync_a <= {cp_event, sleep_pin_n, sdio_in, cs_n, sclk};
            sync_b <= sync_a;
            sclk_d <= sclk_s;
            cs_d <= cs_s;
            cp_d <= cp_s;
        end
    end

    assign sclk_s = sync_b[0];
    assign cs_s = sync_b[1];
    assign din_s = sync_b[2];
    assign sleep_s = ~sync_b[3];
    assign cp_s = sync_b[4];
    assign rise = sclk_s & ~sclk_d;
    assign fall = ~sclk_s & sclk_d;
    assign cs_rise = cs_s & ~cs_d;
    assign cp_rise = cp_s & ~cp_d;

    logic [7:0] cfg, pbuf, dbuf, pact, dact;
    logic [7:0] next_cfg, next_pbuf, next_dbuf, next_pact, next_dact;
    logic [3:0] align, next_align;
    logic gap, next_gap, gate, next_gate;
    logic lsb, sdo_mode, soft_rst;

    assign lsb = cfg[CFG_LSB_BIT];
    assign sdo_mode = cfg[CFG_SDO_BIT];
    assign soft_rst = cfg[CFG_SRST_BIT] | cfg[CFG_SRST_MIR];

    // Readback of the write buffer; unmapped addresses read zero
    function automatic logic [7:0] rd_mux(input logic [12:0] a);
        case (a)
            ADDR_CFG: rd_mux = cfg;
            ADDR_PLL: rd_mux = pbuf;
            ADDR_DIST: rd_mux = dbuf;
            default: rd_mux = 8'h00;
        endcase
    endfunction

    scp_state_type st, next_st;
    logic [3:0] cnt, next_cnt;
    logic [15:0] sh, next_sh, shin;
    logic [7:0] bsh, rsh, next_rsh;
    logic [12:0] addr, next_addr, step;
    logic [1:0] len, next_len, left, next_left;
    logic is_rd, next_rd, obit, next_obit, ract, next_ract;
    logic push, pop, fifo_ready;
    logic pop_valid;
    logic [20:0] fifo_out;

    // Bit order follows the LSB-first bit at once
    assign shin = lsb ? {din_s, sh[15:1]} : {sh[14:0], din_s};
    assign bsh = lsb ? {din_s, sh[7:1]} : {sh[6:0], din_s};
    // Decrement wraps from zero to the last address
    assign step = lsb ? addr + ADDR_STEP
        : (addr == 13'h000 ? ADDR_LAST : addr - ADDR_STEP);

    // Serial sequencer; runs regardless of the sleep pin
    always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_sh = sh;
        next_rd = is_rd;
        next_len = len;
        next_addr = addr;
        next_left = left;
        next_rsh = rsh;
        next_obit = obit;
        next_ract = ract;
        push = 1'b0;
        if (cs_rise) begin
            // Byte-boundary rise stalls the instruction phase or a counted transfer, else it ends
            if (st == ST_DONE || cnt[2:0] != 3'h0
                || (st == ST_DATA && len == LEN_STREAM)) begin
                next_st = ST_INSTR;
                next_cnt = 4'h0;
                next_ract = 1'b0;
            end
        end else if (!cs_s && rise) begin
            case (st)
                ST_INSTR: begin
                    next_sh = shin;
                    next_cnt = cnt + 4'h1;
                    if (cnt == INSTR_LAST) begin
                        next_st = ST_DATA;
                        next_cnt = 4'h0;
                        next_rd = shin[15];
                        next_len = shin[14:13];
                        next_left = shin[14:13];
                        next_addr = shin[12:0];
                        next_rsh = rd_mux(shin[12:0]);
                    end
                end
                ST_DATA: begin
                    next_sh = {sh[15:8], bsh};
                    next_cnt = {1'b0, cnt[2:0] + 3'h1};
                    if (cnt[2:0] == BYTE_LAST) begin
                        push = !is_rd;
                        next_cnt = 4'h0;
                        if (len == LEN_STREAM ? addr == ADDR_LAST
                            : left == 2'h0) begin
                            next_st = ST_DONE;
                        end else begin
                            next_addr = step;
                            next_left = left - 2'h1;
                            next_rsh = rd_mux(step);
                        end
                    end
                end
                ST_DONE: begin
                end
                default: next_st = ST_INSTR;
            endcase
        end else if (!cs_s && fall && st == ST_DATA && is_rd) begin
            next_obit = lsb ? rsh[0] : rsh[7];
            next_rsh = lsb ? {1'b0, rsh[7:1]} : {rsh[6:0], 1'b0};
            next_ract = 1'b1;
        end
        if (!rst_n) begin
            next_st = ST_INSTR;
            next_cnt = 4'h0;
            next_sh = 16'h0000;
            next_rd = 1'b0;
            next_len = 2'h0;
            next_addr = 13'h0000;
            next_left = 2'h0;
            next_rsh = 8'h00;
            next_obit = 1'b0;
            next_ract = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
        cnt <= next_cnt;
        sh <= next_sh;
        is_rd <= next_rd;
        len <= next_len;
        addr <= next_addr;
        left <= next_left;
        rsh <= next_rsh;
        obit <= next_obit;
        ract <= next_ract;
    end

    // Pins float whenever select is high
    assign sdio_out = obit;
    assign separate_readback_pin = obit;
    assign sdio_oe = ract & ~cs_s & ~sdo_mode;
    assign separate_readback_oe = ract & ~cs_s & sdo_mode;

    // Buffered writes; the apply side pauses a cycle after each byte
    scp_fifo #(
        .WIDTH(21),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data({addr, bsh}),
        .out_valid(pop_valid),
        .out_ready(~gap),
        .out_data(fifo_out)
    );

    logic [12:0] wa;
    logic [7:0] wd;
    assign pop = pop_valid & ~gap;
    assign wa = fifo_out[20:8];
    assign wd = fifo_out[7:0];
    assign write_buf_ready = fifo_ready;

    // Register apply, transfer to active set and alignment timer
    always_comb begin
        next_cfg = cfg;
        next_pbuf = pbuf;
        next_dbuf = dbuf;
        next_pact = pact;
        next_dact = dact;
        next_gap = pop;
        next_align = (align != 4'h0) ? align - 4'h1 : 4'h0;
        // Gate closes on the first pump event once sync mode is active
        next_gate = (pact[1:0] == PLL_SYNC_PD) && (gate || cp_rise);
        if (pop) begin
            case (wa)
                ADDR_CFG: begin
                    // Long-instruction bits always read back set
                    if (wd[CFG_SRST_BIT] | wd[CFG_SRST_MIR]) begin
                        next_cfg = CFG_RESET | (wd & CFG_SRST_MASK);
                    end else begin
                        next_cfg = wd | CFG_LONG_MASK;
                    end
                end
                ADDR_PLL: next_pbuf = wd;
                ADDR_DIST: next_dbuf = wd;
                ADDR_UPD: begin
                    if (wd[UPD_BIT]) begin
                        next_pact = pbuf;
                        next_dact = dbuf;
                    end
                end
                default: begin
                end
            endcase
        end
        // Soft reset acts without waiting for a transfer
        if (soft_rst) begin
            next_pbuf = PLL_RESET;
            next_dbuf = DIST_RESET;
            next_pact = PLL_RESET;
            next_dact = DIST_RESET;
            next_align = 4'(ALIGN_CYC);
        end
        if (!rst_n) begin
            next_cfg = CFG_RESET;
            next_pbuf = PLL_RESET;
            next_dbuf = DIST_RESET;
            next_pact = PLL_RESET;
            next_dact = DIST_RESET;
            next_gap = 1'b0;
            next_gate = 1'b0;
            next_align = 4'(ALIGN_CYC);
        end
    end

    // Reset pin clears the configuration without a clock edge
    always_ff @(posedge clk or negedge hard_reset_n) begin
        if (!hard_reset_n) begin
            cfg <= CFG_RESET;
            pbuf <= PLL_RESET;
            dbuf <= DIST_RESET;
            pact <= PLL_RESET;
            dact <= DIST_RESET;
            gap <= 1'b0;
            gate <= 1'b0;
            align <= 4'(ALIGN_CYC);
        end else begin
            cfg <= next_cfg;
            pbuf <= next_pbuf;
            dbuf <= next_dbuf;
            pact <= next_pact;
            dact <= next_dact;
            gap <= next_gap;
            gate <= next_gate;
            align <= next_align;
        end
    end

    // Power controls; sleep keeps every register, so wake resumes them
    assign pll_off = sleep_s | (pact[1:0] == PLL_ASYNC_PD) | gate;
    assign vco_off = sleep_s;
    assign clk_buf_off = sleep_s;
    assign dividers_off = sleep_s | dact[DIST_PD_BIT];
    assign lvds_cmos_off = sleep_s | dact[DIST_PD_BIT];
    assign dist_bias_off = dact[DIST_PD_BIT];
    // Outputs restart together when every hold source is gone
    assign align_hold = (align != 4'h0) | soft_rst | sleep_s
        | dact[DIST_PD_BIT] | dact[SOFT_SYNC_BIT];

    // Sleep forces protected off; otherwise each output takes its code
    for (genvar i = 0; i < PECL_OUTS; i++) begin : g_pecl
        assign lvpecl_state[2*i+1:2*i] = sleep_s ? PECL_SAFE
            : lvpecl_pd_code[2*i+1:2*i];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !hard_reset_n);

    a_hiz_cs_high: assert property (cs_s |-> !sdio_oe && !separate_readback_oe)
        else $error("data pin driven with select high");
    a_readback_pin: assert property (separate_readback_oe |-> sdo_mode && !sdio_oe)
        else $error("readback on wrong pin");
    a_sleep_off: assert property (sleep_s |-> pll_off && vco_off && clk_buf_off
        && dividers_off && lvds_cmos_off && lvpecl_state[1:0] == PECL_SAFE)
        else $error("sleep left a block powered");
    a_async_pd: assert property (pop && wa == ADDR_UPD && wd[UPD_BIT] && !soft_rst
        && pbuf[1:0] == PLL_ASYNC_PD |=> pll_off)
        else $error("async power-down late");
    a_sync_pd_gate: assert property ($rose(gate) |-> $past(cp_rise))
        else $error("sync power-down without pump event");
    a_update_copy: assert property (pop && wa == ADDR_UPD && wd[UPD_BIT] && !soft_rst
        |=> pact == $past(pbuf) && dact == $past(dbuf))
        else $error("transfer did not copy buffer");
    a_soft_reset: assert property (soft_rst |=> pbuf == PLL_RESET && dact == DIST_RESET)
        else $error("soft reset did not restore defaults");
    a_abort_flush: assert property (cs_rise && st == ST_DATA && cnt[2:0] != 3'h0
        |=> st == ST_INSTR && cnt == 4'h0)
        else $error("off-boundary rise did not abort");
    a_stall_keep: assert property (cs_rise && st == ST_DATA && cnt == 4'h0
        && len != LEN_STREAM |=> st == ST_DATA && $stable(addr))
        else $error("stall lost transfer state");
    a_instr_end: assert property (st == ST_INSTR && !cs_s && rise && cnt == INSTR_LAST
        |=> st == ST_DATA && addr == $past(shin[12:0]))
        else $error("instruction not taken after 16 bits");
    a_reset_align: assert property ($rose(rst_n) |-> align_hold [*4])
        else $error("alignment hold missing after reset");

    c_read: cover property (ract && !cs_s && is_rd);
    c_stall: cover property (cs_rise && st == ST_DATA && cnt == 4'h0);
    c_stream_end: cover property (st == ST_DATA && len == LEN_STREAM && push);
    c_sleep: cover property (sleep_s ##1 !sleep_s);
endmodule

// file: tb/scp_host.sv
// Host model that drives chip select, serial clock and the data pin
`timescale 1ns/1ps
module scp_host (
    input wire logic clk,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic separate_readback_pin,
    input wire logic separate_readback_oe,
    output logic cs_n,
    output logic sclk,
    output logic sdio_in,
    output logic saw_sep
);
    logic hval;
    logic hoe;
    // Idle levels follow the pin pulls: select high, clock low
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        hval = 1'b0;
        hoe = 1'b0;
        saw_sep = 1'b0;
    end
    // A released data line shows the inverse of its last level, never a held copy
    always_comb sdio_in = sdio_oe ? sdio_out : (hoe ? hval : ~hval);
    // Wait n clock edges, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One serial clock period, four system clocks per half
    task automatic bit_io(input logic b, output logic r);
        hval = b; // Data changes while the clock is low
        tick(4);
        r = separate_readback_oe ? separate_readback_pin : sdio_in;
        saw_sep = saw_sep | separate_readback_oe;
        sclk = 1'b1; // Bit taken on this rise
        tick(4);
        sclk = 1'b0;
    endtask
    // Instruction, optional byte-boundary stall, then nb data bits
    task automatic xfer(input logic [15:0] ins, input int nb, input logic [23:0] wd,
                        input bit stall, output logic [23:0] rd);
        logic r;
        rd = '0;
        saw_sep = 1'b0;
        hoe = 1'b1;
        cs_n = 1'b0;
        tick(4);
        for (int i = 15; i >= 0; i--) bit_io(ins[i], r);
        if (stall) begin
            cs_n = 1'b1; // Pause between instruction and data
            tick(12);
            cs_n = 1'b0;
            tick(4);
        end
        hoe = !ins[15];
        for (int i = nb - 1; i >= 0; i--) begin
            bit_io(wd[i], r);
            rd[i] = r;
        end
        tick(2);
        cs_n = 1'b1; // Ends a stream or cuts a byte short
        hoe = 1'b0;
        tick(6);
    endtask
endmodule

// file: tb/scp_port_ctrl_bench.sv
// Self-checking bench for the serial port and power control
`timescale 1ns/1ps
module scp_port_ctrl_bench;
    import scp_pkg::*;
    typedef struct {logic [12:0] a; logic [7:0] d; logic [7:0] e;} scp_row_type;
    logic clk, rst_n, hard_reset_n, sleep_pin_n, cp_event, sclk, cs_n, sdio_in;
    logic sdio_out, sdio_oe, sep_pin, sep_oe, saw_sep, pll_off, vco_off, clk_buf_off;
    logic dividers_off, lvds_cmos_off, dist_bias_off, align_hold, write_buf_ready;
    logic [11:0] lvpecl_pd_code, lvpecl_state;
    logic [23:0] rd;
    int n_errors = 0;
    int tests_run = 0;
    scp_row_type rows [4] = '{'{ADDR_PLL, 8'h02, 8'h02}, '{ADDR_DIST, 8'h01, 8'h01},
        '{13'h0100, 8'h55, 8'h00}, '{ADDR_UPD, 8'h00, 8'h00}};

    scp_port_ctrl i_dut (.clk(clk), .rst_n(rst_n), .hard_reset_n(hard_reset_n),
        .sleep_pin_n(sleep_pin_n), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .separate_readback_pin(sep_pin),
        .separate_readback_oe(sep_oe), .cp_event(cp_event), .lvpecl_pd_code(lvpecl_pd_code),
        .pll_off(pll_off), .vco_off(vco_off), .clk_buf_off(clk_buf_off),
        .dividers_off(dividers_off), .lvds_cmos_off(lvds_cmos_off),
        .dist_bias_off(dist_bias_off), .lvpecl_state(lvpecl_state),
        .align_hold(align_hold), .write_buf_ready(write_buf_ready));
    scp_host i_host (.clk(clk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .separate_readback_pin(sep_pin), .separate_readback_oe(sep_oe),
        .cs_n(cs_n), .sclk(sclk), .sdio_in(sdio_in), .saw_sep(saw_sep));

    // Verdict in one place; a timeout lands here too
    task automatic close_out;
        if (n_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Single-byte write and read, MSB first
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        i_host.xfer({1'b0, 2'b00, a}, 8, {16'h0, d}, 1'b0, rd);
    endtask
    task automatic rdb(input logic [12:0] a, input logic [7:0] e, input string nm);
        i_host.xfer({1'b1, 2'b00, a}, 8, 24'h0, 1'b0, rd);
        chk(nm, {16'h0, e}, {16'h0, rd[7:0]});
    endtask
    task automatic upd;
        wr(ADDR_UPD, 8'h01);
    endtask

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Watchdog well above the run length
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        close_out();
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        hard_reset_n = 1'b1;
        sleep_pin_n = 1'b1;
        cp_event = 1'b0;
        lvpecl_pd_code = {PECL_TOTAL, PECL_SAFE, PECL_NORMAL, PECL_TOTAL, PECL_SAFE, PECL_NORMAL};
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        i_host.tick(3);
        chk("align_hold early", 24'h1, 24'(align_hold));
        chk("oe idle", 24'h0, 24'({sdio_oe, sep_oe}));
        i_host.tick(3);
        chk("align_hold late", 24'h0, 24'(align_hold));
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rdb(rows[i].a, rows[i].e, "row readback");
        end
        chk("shared pin default", 24'h0, 24'(saw_sep));
        chk("buffer ready", 24'h1, 24'(write_buf_ready));
        // PLL modes only act after the transfer command
        wr(ADDR_PLL, {6'h0, PLL_ASYNC_PD});
        chk("pll before update", 24'h0, 24'(pll_off));
        upd();
        chk("pll async", 24'h1, 24'(pll_off));
        wr(ADDR_PLL, {6'h0, PLL_SYNC_PD});
        upd();
        chk("pll sync gated", 24'h0, 24'(pll_off));
        cp_event = 1'b1;
        i_host.tick(6);
        cp_event = 1'b0;
        chk("pll sync off", 24'h1, 24'(pll_off));
        wr(ADDR_PLL, 8'h00);
        upd();
        // Distribution power-down, outputs follow their codes
        wr(ADDR_DIST, 8'h02);
        upd();
        chk("dist off", 24'h7, 24'({dist_bias_off, dividers_off, lvds_cmos_off}));
        chk("pecl codes", 24'hE38, 24'(lvpecl_state));
        wr(ADDR_DIST, 8'h00);
        upd();
        chk("dist on", 24'h0, 24'(dist_bias_off));
        // Sleep pin: all but the distribution bias off, port still answers
        sleep_pin_n = 1'b0;
        i_host.tick(4);
        chk("sleep offs", 24'h1F, 24'({pll_off, vco_off, clk_buf_off, dividers_off,
            lvds_cmos_off}));
        chk("sleep pecl", 24'hAAA, 24'(lvpecl_state));
        wr(ADDR_PLL, 8'h01);
        rdb(ADDR_PLL, 8'h01, "sleep readback");
        sleep_pin_n = 1'b1;
        i_host.tick(4);
        chk("wake", 24'h0, 24'({pll_off, vco_off, clk_buf_off}));
        // Host realigns the outputs after wake through the soft sync bit
        wr(ADDR_DIST, 8'h01);
        upd();
        chk("wake align", 24'h1, 24'(align_hold));
        wr(ADDR_DIST, 8'h00);
        upd();
        chk("wake aligned", 24'h0, 24'(align_hold));
        lvpecl_pd_code = {6{PECL_TOTAL}};
        i_host.tick(1);
        chk("pecl recode", 24'hFFF, 24'(lvpecl_state));
        // Two-byte write decrements: second byte lands at 0x010
        i_host.xfer({1'b0, 2'b01, 13'h011}, 16, 24'h0099_02, 1'b0, rd);
        i_host.xfer({1'b1, 2'b01, 13'h011}, 16, 24'h0, 1'b0, rd);
        chk("two byte read", 24'h0002, 24'(rd[15:0]));
        // Stream wraps from 0x000 to the last address, then stops
        i_host.xfer({1'b1, LEN_STREAM, 13'h001}, 24, 24'h0, 1'b0, rd);
        chk("stream read", 24'h001800, rd);
        i_host.xfer({1'b0, 2'b00, ADDR_PLL}, 8, 24'h12, 1'b1, rd);
        rdb(ADDR_PLL, 8'h12, "stall write");
        i_host.xfer({1'b0, 2'b00, ADDR_PLL}, 4, 24'h5, 1'b0, rd);
        rdb(ADDR_PLL, 8'h12, "abort write");
        // Stall, then a select rise after two data bits abandons the transfer
        i_host.xfer({1'b0, 2'b00, ADDR_PLL}, 2, 24'h3, 1'b1, rd);
        rdb(ADDR_PLL, 8'h12, "stall abandon");
        // Readback moves to the separate pin
        wr(ADDR_CFG, 8'h99);
        rdb(ADDR_PLL, 8'h12, "separate read");
        chk("separate used", 24'h1, 24'(saw_sep));
        chk("oe released", 24'h0, 24'({sdio_oe, sep_oe}));
        wr(ADDR_CFG, 8'h18);
        // Soft reset needs no transfer command
        wr(ADDR_CFG, 8'h3C);
        chk("soft hold", 24'h1, 24'(align_hold));
        wr(ADDR_CFG, 8'h18);
        rdb(ADDR_PLL, 8'h00, "soft defaults");
        // Hard reset pin
        wr(ADDR_DIST, 8'h04);
        hard_reset_n = 1'b0;
        i_host.tick(2);
        hard_reset_n = 1'b1;
        i_host.tick(2);
        rdb(ADDR_DIST, 8'h00, "hard defaults");
        close_out();
    end
endmodule
